// [hw/capture_pll_control_regs.sv]
// control register bank of the capture clock generator and red gain
`timescale 1ns/1ps
`include "capture_pll_cfg.svh"
module capture_pll_control_regs
  import capture_pll_pkg::*;
#(
  // arbitrary neutral value
  parameter logic [7:0] SILICON_REVISION = 8'h01
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire reg_req_t req_in,
  input wire logic [11:0] lines_per_frame_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output pll_cfg_t cfg_out,
  output logic divide_ratio_valid_out,
  output logic [11:0] active_divide_ratio_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] div_upper_ff, nxt_div_upper;
  logic [7:0] div_lower_ff, nxt_div_lower;
  logic [7:0] clkgen_ff, nxt_clkgen;
  logic [7:0] phase_ff, nxt_phase;
  logic [7:0] gain_upper_ff, nxt_gain_upper;
  logic [7:0] gain_lower_ff, nxt_gain_lower;
  logic [7:0] fact_a_ff, nxt_fact_a;
  logic [7:0] fact_b_ff, nxt_fact_b;
  logic [7:0] hold_ff, nxt_hold;
  logic [7:0] fact_c_ff, nxt_fact_c;
  logic [7:0] fact_d_ff, nxt_fact_d;
  logic [11:0] ratio_ff, nxt_ratio;
  logic [8:0] gain_ff, nxt_gain;
  logic [7:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;

  function automatic logic hit(input reg_req_t r, input logic [7:0] a);
    hit = r.write && (r.addr == a);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_div_upper = div_upper_ff;
    nxt_div_lower = div_lower_ff;
    nxt_clkgen = clkgen_ff;
    nxt_phase = phase_ff;
    nxt_gain_upper = gain_upper_ff;
    nxt_gain_lower = gain_lower_ff;
    nxt_fact_a = fact_a_ff;
    nxt_fact_b = fact_b_ff;
    nxt_hold = hold_ff;
    nxt_fact_c = fact_c_ff;
    nxt_fact_d = fact_d_ff;
    nxt_ratio = ratio_ff;
    nxt_gain = gain_ff;
    // RQ6: upper byte only latched
    if (hit(req_in, `ADR_LINE_DIVIDE_UPPER)) begin
      nxt_div_upper = req_in.data;
    end
    // RQ8: low nibble commits ratio
    if (hit(req_in, `ADR_LINE_DIVIDE_LOWER)) begin
      nxt_div_lower = {req_in.data[7:4], 4'h0};
      // RQ19: whole ratio at once
      nxt_ratio = {div_upper_ff, req_in.data[7:4]};
    end
    if (hit(req_in, `ADR_CLOCK_GEN_CONTROL)) begin
      nxt_clkgen = {req_in.data[7:2], 2'b00};
    end
    if (hit(req_in, `ADR_SAMPLE_PHASE)) begin
      nxt_phase = {req_in.data[7:3], 3'b000};
    end
    // RQ17: upper gain latched only
    if (hit(req_in, `ADR_RED_GAIN_UPPER)) begin
      nxt_gain_upper = {1'b0, req_in.data[6:0]};
    end
    // RQ18: low bits commit gain
    if (hit(req_in, `ADR_RED_GAIN_LOWER)) begin
      nxt_gain_lower = {req_in.data[7:6], 6'h00};
      nxt_gain = {gain_upper_ff[6:0], req_in.data[7:6]};
    end
    if (hit(req_in, `ADR_FACTORY_A)) begin
      nxt_fact_a = req_in.data;
    end
    if (hit(req_in, `ADR_FACTORY_B)) begin
      nxt_fact_b = req_in.data;
    end
    // RQ5: hold control stored whole
    if (hit(req_in, `ADR_AUTO_LEVEL_HOLD)) begin
      nxt_hold = req_in.data;
    end
    if (hit(req_in, `ADR_FACTORY_C)) begin
      nxt_fact_c = req_in.data;
    end
    if (hit(req_in, `ADR_FACTORY_D)) begin
      nxt_fact_d = req_in.data;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_upper_ff <= `RST_DIVIDE_UPPER;
      div_lower_ff <= `RST_DIVIDE_LOWER;
      clkgen_ff <= `RST_CLOCK_GEN_CONTROL;
      phase_ff <= `RST_SAMPLE_PHASE;
      gain_upper_ff <= `RST_RED_GAIN_UPPER;
      gain_lower_ff <= `RST_RED_GAIN_LOWER;
      fact_a_ff <= `RST_FACTORY_A;
      fact_b_ff <= `RST_FACTORY_B;
      hold_ff <= `RST_AUTO_LEVEL_HOLD;
      fact_c_ff <= `RST_FACTORY_C;
      fact_d_ff <= `RST_FACTORY_D;
      // RQ11: power-up ratio
      ratio_ff <= `RST_DIVIDE_RATIO;
      gain_ff <= `RST_RED_GAIN;
    end else begin
      div_upper_ff <= nxt_div_upper;
      div_lower_ff <= nxt_div_lower;
      clkgen_ff <= nxt_clkgen;
      phase_ff <= nxt_phase;
      gain_upper_ff <= nxt_gain_upper;
      gain_lower_ff <= nxt_gain_lower;
      fact_a_ff <= nxt_fact_a;
      fact_b_ff <= nxt_fact_b;
      hold_ff <= nxt_hold;
      fact_c_ff <= nxt_fact_c;
      fact_d_ff <= nxt_fact_d;
      ratio_ff <= nxt_ratio;
      gain_ff <= nxt_gain;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data registered; reserved words read zero
  always_comb begin
    nxt_rvalid = req_in.read;
    nxt_rdata = rdata_ff;
    if (req_in.read) begin
      case (req_in.addr)
        // RQ7: revision code
        `ADR_SILICON_REVISION: nxt_rdata = SILICON_REVISION;
        `ADR_LINE_DIVIDE_UPPER: nxt_rdata = div_upper_ff;
        `ADR_LINE_DIVIDE_LOWER: nxt_rdata = div_lower_ff;
        `ADR_CLOCK_GEN_CONTROL: nxt_rdata = clkgen_ff;
        `ADR_SAMPLE_PHASE: nxt_rdata = phase_ff;
        `ADR_RED_GAIN_UPPER: nxt_rdata = gain_upper_ff;
        `ADR_RED_GAIN_LOWER: nxt_rdata = gain_lower_ff;
        // RQ1: line count readback
        `ADR_LINES_UPPER: nxt_rdata = lines_per_frame_in[11:4];
        `ADR_LINES_LOWER: nxt_rdata = {lines_per_frame_in[3:0], 4'h0};
        `ADR_FACTORY_A: nxt_rdata = fact_a_ff;
        `ADR_FACTORY_B: nxt_rdata = fact_b_ff;
        // RQ4: reserved, no storage
        `ADR_RESERVED_A: nxt_rdata = 8'h00;
        `ADR_RESERVED_B: nxt_rdata = 8'h00;
        `ADR_AUTO_LEVEL_HOLD: nxt_rdata = hold_ff;
        `ADR_FACTORY_C: nxt_rdata = fact_c_ff;
        `ADR_FACTORY_D: nxt_rdata = fact_d_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign rdata_out = rdata_ff;
  assign rvalid_out = rvalid_ff;
  assign cfg_out.line_divide_ratio = ratio_ff;
  // RQ12: band field
  assign cfg_out.oscillator_band_select =
    clkgen_ff[`POS_BAND_HI:`POS_BAND_LO];
  // RQ13: pump current code
  assign cfg_out.pump_current = clkgen_ff[`POS_PUMP_HI:`POS_PUMP_LO];
  // RQ14: clock source bit
  assign cfg_out.external_pixel_clock_select = clkgen_ff[`POS_EXT_CLOCK];
  // RQ16: phase applies in either clock mode
  assign cfg_out.sample_phase = phase_ff[`POS_PHASE_HI:`POS_PHASE_LO];
  assign cfg_out.red_gain = gain_ff;
  assign cfg_out.continuous_offset_update = hold_ff[`POS_HOLD_CONT];
  // RQ9: ratios below 2 flagged, the loop must not use them
  assign divide_ratio_valid_out = (ratio_ff >= `MIN_DIVIDE_RATIO);
  // RQ15: ratio ignored under external clock
  // RQ10: ratio is pixel clocks per line
  assign active_divide_ratio_out =
    clkgen_ff[`POS_EXT_CLOCK] ? 12'h000 : ratio_ff;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  upper_no_commit_a: assert property ( // RQ6
    hit(req_in, `ADR_LINE_DIVIDE_UPPER) |=> $stable(ratio_ff))
    else $error("ratio changed on upper write");
  ratio_commit_a: assert property ( // RQ8
    hit(req_in, `ADR_LINE_DIVIDE_LOWER) |=>
      ratio_ff == {$past(div_upper_ff), $past(req_in.data[7:4])})
    else $error("ratio commit wrong");
  ratio_stable_a: assert property ( // RQ19
    !rst_in && !hit(req_in, `ADR_LINE_DIVIDE_LOWER) |=> $stable(ratio_ff))
    else $error("ratio moved without low write");
  gain_commit_a: assert property ( // RQ18
    hit(req_in, `ADR_RED_GAIN_LOWER) |=>
      gain_ff == {$past(gain_upper_ff[6:0]), $past(req_in.data[7:6])})
    else $error("gain commit wrong");
  gain_stable_a: assert property ( // RQ17
    !rst_in && !hit(req_in, `ADR_RED_GAIN_LOWER) |=> $stable(gain_ff))
    else $error("gain moved without low write");
  reserved_zero_a: assert property ( // RQ4
    req_in.read && (req_in.addr == `ADR_RESERVED_A) |=> rdata_out == 8'h00)
    else $error("reserved read not zero");
  revision_read_a: assert property ( // RQ7
    req_in.read && (req_in.addr == `ADR_SILICON_REVISION) |=>
      rvalid_out && rdata_out == SILICON_REVISION)
    else $error("revision read wrong");
  line_count_a: assert property ( // RQ1
    req_in.read && (req_in.addr == `ADR_LINES_UPPER) |=>
      rdata_out == $past(lines_per_frame_in[11:4]))
    else $error("line count read wrong");
  ext_ignore_a: assert property ( // RQ15
    cfg_out.external_pixel_clock_select |-> active_divide_ratio_out == 12'h000)
    else $error("ratio used under external clock");
  hold_bit_a: assert property ( // RQ5
    hit(req_in, `ADR_AUTO_LEVEL_HOLD) |=>
      cfg_out.continuous_offset_update == $past(req_in.data[4]))
    else $error("hold bit not applied");

  upper_latch_a: assert property ( // RQ6
    hit(req_in, `ADR_LINE_DIVIDE_UPPER) |=>
      div_upper_ff == $past(req_in.data))
    else $error("upper divide byte not latched");
  lower_store_a: assert property ( // RQ8
    hit(req_in, `ADR_LINE_DIVIDE_LOWER) |=>
      div_lower_ff == {$past(req_in.data[7:4]), 4'h0})
    else $error("low divide nibble not stored");
  gain_upper_store_a: assert property ( // RQ17
    hit(req_in, `ADR_RED_GAIN_UPPER) |=>
      gain_upper_ff == {1'b0, $past(req_in.data[6:0])})
    else $error("upper gain bits not stored");
  gain_upper_hold_a: assert property ( // RQ6
    hit(req_in, `ADR_RED_GAIN_UPPER) |=> $stable(gain_ff))
    else $error("gain changed on upper write");
  gain_lower_store_a: assert property ( // RQ18
    hit(req_in, `ADR_RED_GAIN_LOWER) |=>
      gain_lower_ff == {$past(req_in.data[7:6]), 6'h00})
    else $error("low gain bits not stored");
  band_pump_a: assert property ( // RQ12
    hit(req_in, `ADR_CLOCK_GEN_CONTROL) |=>
      cfg_out.oscillator_band_select == $past(req_in.data[7:6]) &&
      cfg_out.pump_current == $past(req_in.data[5:3]))
    else $error("band or pump field wrong");
  ext_select_a: assert property ( // RQ14
    hit(req_in, `ADR_CLOCK_GEN_CONTROL) |=>
      cfg_out.external_pixel_clock_select == $past(req_in.data[2]))
    else $error("clock source bit wrong");
  phase_write_a: assert property ( // RQ16
    hit(req_in, `ADR_SAMPLE_PHASE) |=>
      cfg_out.sample_phase == $past(req_in.data[7:3]))
    else $error("sample phase wrong");
  int_ratio_a: assert property ( // RQ10
    !cfg_out.external_pixel_clock_select |->
      active_divide_ratio_out == cfg_out.line_divide_ratio)
    else $error("ratio not applied under internal clock");
  ratio_floor_a: assert property ( // RQ9
    cfg_out.line_divide_ratio < 12'h002 |-> !divide_ratio_valid_out)
    else $error("ratio below two flagged valid");
  reset_values_a: assert property ( // RQ11
    $past(rst_in) |-> ratio_ff == `RST_DIVIDE_RATIO &&
      clkgen_ff == `RST_CLOCK_GEN_CONTROL &&
      phase_ff == `RST_SAMPLE_PHASE && gain_ff == `RST_RED_GAIN)
    else $error("settings not at power-up values");
  rvalid_pulse_a: assert property ( // RQ7
    !req_in.read |=> !rvalid_out)
    else $error("read valid without request");
  rdata_hold_a: assert property ( // RQ7
    !rst_in && !req_in.read |=> $stable(rdata_out))
    else $error("read data moved without read");
  reserved_b_zero_a: assert property ( // RQ4
    req_in.read && (req_in.addr == `ADR_RESERVED_B) |=> rdata_out == 8'h00)
    else $error("second reserved read not zero");
  lines_lower_a: assert property ( // RQ1
    req_in.read && (req_in.addr == `ADR_LINES_LOWER) |=>
      rdata_out == {$past(lines_per_frame_in[3:0]), 4'h0})
    else $error("line count low read wrong");

  ratio_write_c: cover property (
    hit(req_in, `ADR_LINE_DIVIDE_UPPER) ##1 hit(req_in, `ADR_LINE_DIVIDE_LOWER));
  gain_write_c: cover property (hit(req_in, `ADR_RED_GAIN_LOWER));
  ext_clock_c: cover property (cfg_out.external_pixel_clock_select);
  line_read_c: cover property (req_in.read && req_in.addr == `ADR_LINES_LOWER);
  ext_phase_c: cover property (
    cfg_out.external_pixel_clock_select && hit(req_in, `ADR_SAMPLE_PHASE));

endmodule : capture_pll_control_regs

// [hw/capture_pll_cfg.svh]
// register offsets, field positions and reset values of the capture control bank
// Operation
// RQ1: line count readable at 0x26 and 0x27
// RQ2: host writes 0xbf and 0x02 to 0x28/0x29
// RQ3: host writes 0xe8 and 0xe0 to 0x2d/0x2e
// RQ4: 0x2a and 0x2b read only, writes ignored
// RQ5: bit4 of 0x2c selects hold or continuous
// RQ6: wide settings update only on low write
// RQ7: address 0x00 returns silicon revision code
// RQ8: divide ratio 12 bits from 0x01, 0x02
// RQ9: divider accepts ratios 2 through 4095
// RQ10: ratio sets pixel clocks per line
// RQ11: divide ratio resets to 1693
// RQ12: band select bits 7:6 reset to 01
// RQ13: pump current bits 5:3 reset to 001
// RQ14: bit 2 selects external pixel clock
// RQ15: external clock ignores ratio, keeps phase
// RQ16: phase field bits 7:3 resets to 16
// RQ17: red gain upper bits 6:0 reset 0x40
// RQ18: red gain low bits 7:6 commit gain
// RQ19: whole wide value applied in one cycle
`ifndef CAPTURE_PLL_CFG_SVH
`define CAPTURE_PLL_CFG_SVH
`define ADR_SILICON_REVISION 8'h00
`define ADR_LINE_DIVIDE_UPPER 8'h01
`define ADR_LINE_DIVIDE_LOWER 8'h02
`define ADR_CLOCK_GEN_CONTROL 8'h03
`define ADR_SAMPLE_PHASE 8'h04
`define ADR_RED_GAIN_UPPER 8'h05
`define ADR_RED_GAIN_LOWER 8'h06
`define ADR_LINES_UPPER 8'h26
`define ADR_LINES_LOWER 8'h27
`define ADR_FACTORY_A 8'h28
`define ADR_FACTORY_B 8'h29
`define ADR_RESERVED_A 8'h2a
`define ADR_RESERVED_B 8'h2b
`define ADR_AUTO_LEVEL_HOLD 8'h2c
`define ADR_FACTORY_C 8'h2d
`define ADR_FACTORY_D 8'h2e
`define RST_DIVIDE_UPPER 8'h69
`define RST_DIVIDE_LOWER 8'hd0
`define RST_DIVIDE_RATIO 12'h69d
`define RST_CLOCK_GEN_CONTROL 8'h48
`define RST_SAMPLE_PHASE 8'h80
`define RST_RED_GAIN_UPPER 8'h40
`define RST_RED_GAIN_LOWER 8'h00
`define RST_RED_GAIN 9'h100
`define RST_FACTORY_A 8'hbf
`define RST_FACTORY_B 8'h02
`define RST_AUTO_LEVEL_HOLD 8'h00
`define RST_FACTORY_C 8'hf0
`define RST_FACTORY_D 8'hf0
`define POS_BAND_HI 7
`define POS_BAND_LO 6
`define POS_PUMP_HI 5
`define POS_PUMP_LO 3
`define POS_EXT_CLOCK 2
`define POS_PHASE_HI 7
`define POS_PHASE_LO 3
`define POS_HOLD_CONT 4
`define MIN_DIVIDE_RATIO 12'h002
`endif

// [hw/capture_pll_pkg.sv]
// types shared by the capture control bank
package capture_pll_pkg;
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_t;
  typedef struct packed {
    logic [11:0] line_divide_ratio;
    logic [1:0] oscillator_band_select;
    logic [2:0] pump_current;
    logic external_pixel_clock_select;
    logic [4:0] sample_phase;
    logic [8:0] red_gain;
    logic continuous_offset_update;
  } pll_cfg_t;
endpackage : capture_pll_pkg

// [bench/host_regs_model.sv]
// host model issuing register writes and reads
`timescale 1ns/1ps
module host_regs_model
  import capture_pll_pkg::*;
(
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  output reg_req_t req_out
);
  initial req_out = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req_out <= '{1'b1, 1'b0, a, d};
    @(posedge clk_in);
    req_out <= '0;
    #1;
  endtask : wr
  // returns rvalid beside data, sampled one cycle after the request
  task automatic rd(input logic [7:0] a, output logic [8:0] r);
    @(posedge clk_in);
    req_out <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_in);
    req_out <= '0;
    #1;
    r = {rvalid_in, rdata_in};
  endtask : rd
  task automatic setup();
    wr(8'h28, 8'hbf);
    wr(8'h29, 8'h02);
    wr(8'h2d, 8'he8);
    wr(8'h2e, 8'he0);
    wr(8'h2c, 8'h00);
  endtask : setup
endmodule : host_regs_model

// [bench/capture_pll_control_regs_bench.sv]
// self-checking bench of the capture control register bank
`timescale 1ns/1ps
module capture_pll_control_regs_bench;
  import capture_pll_pkg::*;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;
  // arbitrary revision value
  localparam logic [7:0] REV = 8'h5a;
  logic clk_in, rst_in, rvalid, dv;
  logic [11:0] lines, act;
  logic [7:0] rdata;
  logic [8:0] r, r2;
  reg_req_t req;
  pll_cfg_t cfg, ex;
  int checks = 0;
  int n_fail = 0;
  logic [15:0] bw[3] = '{16'h0020, 16'h0010, 16'hfff0};
  logic [2:0] bv = 3'b101;
  row_t rows[14] = '{
    '{1'b0, 8'h00, 8'h00, REV}, '{1'b0, 8'h01, 8'h00, 8'h69},
    '{1'b0, 8'h02, 8'h00, 8'hd0}, '{1'b0, 8'h03, 8'h00, 8'h48},
    '{1'b0, 8'h04, 8'h00, 8'h80}, '{1'b0, 8'h05, 8'h00, 8'h40},
    '{1'b0, 8'h06, 8'h00, 8'h00}, '{1'b0, 8'h28, 8'h00, 8'hbf},
    '{1'b0, 8'h29, 8'h00, 8'h02}, '{1'b0, 8'h2d, 8'h00, 8'hf0},
    '{1'b0, 8'h2e, 8'h00, 8'hf0}, '{1'b0, 8'h2c, 8'h00, 8'h00},
    '{1'b1, 8'h00, 8'hff, REV}, '{1'b1, 8'h7f, 8'h33, 8'h00}};
  capture_pll_control_regs #(.SILICON_REVISION(REV)) uut (
    .clk_in(clk_in), .rst_in(rst_in), .req_in(req),
    .lines_per_frame_in(lines), .rdata_out(rdata), .rvalid_out(rvalid),
    .cfg_out(cfg), .divide_ratio_valid_out(dv),
    .active_divide_ratio_out(act));
  host_regs_model host (
    .clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .req_out(req));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp,
                     input string what);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // run needs under 400 cycles
  initial begin
    #100us;
    n_fail++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_in = 1'b1;
    lines = 12'h000;
    ex = '{12'h69d, 2'b01, 3'b001, 1'b0, 5'd16, 9'h100, 1'b0};
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w)
        host.wr(rows[i].a, rows[i].d);
      host.rd(rows[i].a, r);
      chk(36'(r), 36'({1'b1, rows[i].e}), "readback");
    end
    chk(36'(cfg), 36'(ex), "cfg reset");
    chk(36'({dv, act}), 36'({1'b1, 12'h69d}), "active ratio");
    host.setup();
    host.rd(8'h2d, r);
    chk(36'(r), 36'(9'h1e8), "factory c");
    @(posedge clk_in);
    lines <= 12'habc;
    host.rd(8'h26, r);
    chk(36'(r), 36'(9'h1ab), "lines upper");
    host.rd(8'h27, r);
    chk(36'(r), 36'(9'h1c0), "lines lower");
    host.wr(8'h01, 8'h10);
    chk(36'(cfg.line_divide_ratio), 36'(12'h69d), "ratio held");
    host.wr(8'h02, 8'h40);
    chk(36'(cfg.line_divide_ratio), 36'(12'h104), "commit");
    foreach (bw[i]) begin
      host.wr(8'h01, bw[i][15:8]);
      host.wr(8'h02, bw[i][7:0]);
      chk(36'({dv, act}), 36'({bv[i], bw[i][15:4]}), "range");
    end
    host.wr(8'h03, 8'h4c);
    host.wr(8'h04, 8'hf8);
    chk(36'({cfg.external_pixel_clock_select, cfg.sample_phase, act}),
        36'({1'b1, 5'd31, 12'h000}), "ext clock");
    host.wr(8'h03, 8'h48);
    chk(36'(act), 36'(12'hfff), "int clock");
    for (int i = 0; i < 8; i++) begin
      host.wr(8'h03, {i[1:0], i[2:0], 3'b000});
      chk(36'({cfg.oscillator_band_select, cfg.pump_current}),
          36'({i[1:0], i[2:0]}), "band pump");
    end
    host.wr(8'h05, 8'h7f);
    chk(36'(cfg.red_gain), 36'(9'h100), "gain held");
    host.rd(8'h05, r);
    chk(36'(r), 36'(9'h17f), "gain upper");
    host.wr(8'h06, 8'hc0);
    chk(36'(cfg.red_gain), 36'(9'h1ff), "gain commit");
    host.wr(8'h2c, 8'h10);
    chk(36'(cfg.continuous_offset_update), 36'(1'b1), "offset");
    host.wr(8'h2a, 8'hff);
    host.wr(8'h2b, 8'hff);
    host.rd(8'h2a, r);
    host.rd(8'h2b, r2);
    chk(36'(r), 36'(9'h100), "reserved a");
    chk(36'(r2), 36'(9'h100), "reserved b");
    // second reset in mid-run must restore every setting
    @(posedge clk_in);
    rst_in <= 1'b1;
    @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    chk(36'(cfg), 36'(ex), "cfg rearm");
    host.rd(8'h02, r);
    chk(36'(r), 36'(9'h1d0), "lower rearm");
    results();
  end
endmodule : capture_pll_control_regs_bench
